/* rtl/dbws_pkg.sv */
// Behaviour
// - both width inputs asserted means 8-bit
// - 16-bit width splits into up to two cycles
// - 8-bit width splits into up to four cycles
// - follow-ons get fresh enables, same word address
// - 8-bit next lane-enable pattern table
// - 16-bit next lane-enable pattern table
// - take read data from width-specific lanes
// - write data only on enabled lanes
// - width sampled in clock before cycle done
// - I/O waits for drained write buffer
// - 4 GB memory and 64 KB I/O space
// - I/O ports of any width within 64 KB
package dbws_pkg;

  // ==========================================================================
  // widths and constants
  localparam int          ADDR_W      = 30;
  localparam int          DATA_W      = 32;
  localparam int          LANES       = 4;
  localparam logic [15:0] IO_TOP      = 16'hffff;
  localparam logic [3:0]  NO_LANES    = 4'hf;
  localparam logic [1:0]  WB_DEPTH    = 2'h2;

  // ==========================================================================
  // bus width decode
  typedef enum logic [1:0] {
    DBWS_W32 = 2'b00,
    DBWS_W16 = 2'b01,
    DBWS_W8  = 2'b10
  } dbws_width_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic                     is_io;
    logic                     write;
    logic [ADDR_W-1:0]        word_addr;
    logic [LANES-1:0]         lane_enable_n;
    logic [DATA_W-1:0]        wdata;
  } dbws_req_t;

  typedef struct packed {
    logic [DATA_W-1:0]        rdata;
    logic                     write;
  } dbws_resp_t;

endpackage

/* rtl/dbws_lane_next.sv */
`timescale 1ns/100ps
module dbws_lane_next (
  // current cycle
  input  wire logic [3:0]           cur_n,
  input  wire dbws_pkg::dbws_width_t width,
  // result
  output logic      [3:0]           next_n,
  output logic                      more,
  output logic      [3:0]           take
);

  // ==========================================================================
  // next lane pattern and lanes carrying valid data
  always_comb begin
    next_n = dbws_pkg::NO_LANES;
    take   = ~cur_n;
    unique case (width)
      dbws_pkg::DBWS_W8: begin
        unique case (cur_n)
          4'hc:    next_n = 4'hd;
          4'h8:    next_n = 4'h9;
          4'h0:    next_n = 4'h1;
          4'h9:    next_n = 4'hb;
          4'h1:    next_n = 4'h3;
          4'h3:    next_n = 4'h7;
          default: next_n = dbws_pkg::NO_LANES;
        endcase
        take = (~cur_n) & ~((~cur_n) - 4'h1);
      end
      dbws_pkg::DBWS_W16: begin
        unique case (cur_n)
          4'h8, 4'h9: next_n = 4'hb;
          4'h0, 4'h1: next_n = 4'h3;
          default:    next_n = dbws_pkg::NO_LANES;
        endcase
        // low half if byte 0 or 1 enabled
        take = (~cur_n[1:0] != 2'h0) ? {2'h0, ~cur_n[1:0]} : {~cur_n[3:2], 2'h0};
      end
      default: begin
        next_n = dbws_pkg::NO_LANES;
        take   = ~cur_n;
      end
    endcase
    more = (next_n != dbws_pkg::NO_LANES);
  end

endmodule

/* rtl/dbws_skid.sv */
`timescale 1ns/100ps
module dbws_skid (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // fill side
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire dbws_pkg::dbws_resp_t in_data,
  // drain side
  output logic                     out_valid,
  input  wire logic                out_ready,
  output dbws_pkg::dbws_resp_t     out_data
);

  // ==========================================================================
  // two-entry buffer, output from a register
  dbws_pkg::dbws_resp_t mem_ff [2];
  logic                 wp_ff;
  logic                 rp_ff;
  logic [1:0]           cnt_ff;
  logic                 push;
  logic                 pop;

  assign in_ready  = (cnt_ff != dbws_pkg::WB_DEPTH);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_ff  <= 1'b0;
      rp_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) wp_ff <= ~wp_ff;
      if (pop) rp_ff <= ~rp_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

/* rtl/dbws_core.sv */
`timescale 1ns/100ps
module dbws_core (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // request side
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire dbws_pkg::dbws_req_t  req,
  input  wire logic                 wbuf_empty,
  // response side
  output logic                      resp_valid,
  input  wire logic                 resp_ready,
  output dbws_pkg::dbws_resp_t      resp,
  // processor bus
  output logic                      bus_start_ff,
  output logic                      bus_io_ff,
  output logic                      bus_write_ff,
  output logic [29:0]               upper_word_address_ff,
  output logic [3:0]                lane_enable_n_ff,
  output logic [31:0]               data_lanes_out_ff,
  output logic [3:0]                data_lanes_oe_ff,
  input  wire logic [31:0]          data_lanes_in,
  input  wire logic                 width16_request_n,
  input  wire logic                 width8_request_n,
  input  wire logic                 cycle_done_n
);

  // ==========================================================================
  // state
  typedef enum logic [1:0] {
    DBWS_IDLE  = 2'b00,
    DBWS_DRAIN = 2'b01,
    DBWS_BUS   = 2'b10,
    DBWS_DONE  = 2'b11
  } dbws_state_t;

  dbws_state_t           state_ff;
  dbws_pkg::dbws_width_t width_ff;
  dbws_pkg::dbws_width_t width_now;
  logic [31:0]           merge_ff;
  logic [3:0]            next_n;
  logic                  more;
  logic [3:0]            take;
  logic                  buf_ready;
  logic                  done;
  logic [31:0]           merged;
  dbws_pkg::dbws_resp_t  buf_in;

  assign req_ready = (state_ff == DBWS_IDLE);
  assign done      = (state_ff == DBWS_BUS) && !cycle_done_n;

  // ==========================================================================
  // width decode and sampling
  // both asserted gives 8-bit
  assign width_now = !width8_request_n  ? dbws_pkg::DBWS_W8  :
                     !width16_request_n ? dbws_pkg::DBWS_W16 : dbws_pkg::DBWS_W32;

  // sample every clock, use value before done
  always_ff @(posedge clk or posedge reset) begin
    if (reset) width_ff <= dbws_pkg::DBWS_W32;
    else width_ff <= width_now;
  end

  dbws_lane_next u_next (
    .cur_n  (lane_enable_n_ff),
    .width  (width_ff),
    .next_n (next_n),
    .more   (more),
    .take   (take)
  );

  // ==========================================================================
  // read merge
  // capture only valid lanes
  generate
    for (genvar i = 0; i < 4; i++) begin : g_lane
      assign merged[8*i +: 8] = take[i] ? data_lanes_in[8*i +: 8] : merge_ff[8*i +: 8];
    end
  endgenerate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) merge_ff <= 32'h0;
    else if (state_ff == DBWS_IDLE) merge_ff <= 32'h0;
    else if (done && !bus_write_ff) merge_ff <= merged;
  end

  // ==========================================================================
  // sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= DBWS_IDLE;
    end else begin
      unique case (state_ff)
        DBWS_IDLE: begin
          if (req_valid) state_ff <= req.is_io ? DBWS_DRAIN : DBWS_BUS;
        end
        // I/O waits for empty write buffer
        DBWS_DRAIN: begin
          if (wbuf_empty) state_ff <= DBWS_BUS;
        end
        DBWS_BUS: begin
          if (done && !more) state_ff <= DBWS_DONE;
        end
        DBWS_DONE: begin
          if (buf_ready) state_ff <= DBWS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // bus outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_io_ff             <= 1'b0;
      bus_write_ff          <= 1'b0;
      upper_word_address_ff <= 30'h0;
      lane_enable_n_ff      <= 4'hf;
      data_lanes_out_ff     <= 32'h0;
      data_lanes_oe_ff      <= 4'h0;
    end else if (state_ff == DBWS_IDLE && req_valid) begin
      bus_io_ff             <= req.is_io;
      bus_write_ff          <= req.write;
      // I/O addresses limited to 64 KB
      upper_word_address_ff <= req.is_io ? {16'h0, req.word_addr[13:0]} : req.word_addr;
      lane_enable_n_ff      <= req.lane_enable_n;
      for (int i = 0; i < 4; i++) begin
        data_lanes_out_ff[8*i +: 8] <= req.lane_enable_n[i] ? 8'h0 : req.wdata[8*i +: 8];
      end
      data_lanes_oe_ff      <= req.write ? 4'hf : 4'h0;
    end else if (done && more) begin
      lane_enable_n_ff <= next_n;
      for (int i = 0; i < 4; i++) begin
        if (next_n[i]) data_lanes_out_ff[8*i +: 8] <= 8'h0;
      end
    end else if (done) begin
      data_lanes_oe_ff <= 4'h0;
    end
  end

  // one start strobe per narrow cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) bus_start_ff <= 1'b0;
    else bus_start_ff <= (state_ff == DBWS_IDLE && req_valid && !req.is_io)
                         || (state_ff == DBWS_DRAIN && wbuf_empty) || (done && more);
  end

  // ==========================================================================
  // response buffer
  assign buf_in.rdata = merge_ff;
  assign buf_in.write = bus_write_ff;

  dbws_skid u_skid (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (state_ff == DBWS_DONE),
    .in_ready  (buf_ready),
    .in_data   (buf_in),
    .out_valid (resp_valid),
    .out_ready (resp_ready),
    .out_data  (resp)
  );

  // ==========================================================================
  // checks
  // I/O port range within 64 KB
  io_range_a: assert property (@(posedge clk) disable iff (reset)
    bus_io_ff |-> upper_word_address_ff[29:14] == 16'h0) else $error("io address out of range");
  drain_first_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == DBWS_DRAIN && !wbuf_empty) |=> !bus_start_ff) else $error("io before drain");
  addr_hold_a: assert property (@(posedge clk) disable iff (reset)
    (done && more) |=> $stable(upper_word_address_ff)) else $error("address moved");
  next_lane_a: assert property (@(posedge clk) disable iff (reset)
    (done && more && width_ff == dbws_pkg::DBWS_W8 && lane_enable_n_ff == 4'h0)
    |=> lane_enable_n_ff == 4'h1) else $error("bad 8-bit next enables");
  next16_a: assert property (@(posedge clk) disable iff (reset)
    (done && more && width_ff == dbws_pkg::DBWS_W16 && lane_enable_n_ff == 4'h8)
    |=> lane_enable_n_ff == 4'hb) else $error("bad 16-bit next enables");
  width8_a: assert property (@(posedge clk) disable iff (reset)
    (!width8_request_n && !width16_request_n) |=> width_ff == dbws_pkg::DBWS_W8)
    else $error("both asserted not 8-bit");
  wdata_lane_a: assert property (@(posedge clk) disable iff (reset)
    (lane_enable_n_ff[3] && data_lanes_oe_ff[3]) |-> data_lanes_out_ff[31:24] == 8'h0)
    else $error("write data on disabled lane");
  finish_a: assert property (@(posedge clk) disable iff (reset)
    (done && !more) |=> state_ff == DBWS_DONE) else $error("finish missed");
  split_a: assert property (@(posedge clk) disable iff (reset)
    (done && width_ff == dbws_pkg::DBWS_W16 && lane_enable_n_ff == 4'h0) |-> more)
    else $error("16-bit split missing");
  four_a: assert property (@(posedge clk) disable iff (reset)
    (done && width_ff == dbws_pkg::DBWS_W8 && lane_enable_n_ff == 4'h3) |-> more)
    else $error("8-bit split missing");

  io_wait_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == DBWS_IDLE && req_valid && req.is_io)
    |=> (state_ff == DBWS_DRAIN && !bus_start_ff)) else $error("io skipped drain");

  mem_go_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == DBWS_IDLE && req_valid && !req.is_io)
    |=> (state_ff == DBWS_BUS && bus_start_ff)) else $error("memory start late");

  drain_go_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == DBWS_DRAIN && wbuf_empty)
    |=> (state_ff == DBWS_BUS && bus_start_ff)) else $error("io start late");

  width16_a: assert property (@(posedge clk) disable iff (reset)
    (!width16_request_n && width8_request_n)
    |=> width_ff == dbws_pkg::DBWS_W16) else $error("16-bit width not taken");

  width32_a: assert property (@(posedge clk) disable iff (reset)
    (width16_request_n && width8_request_n)
    |=> width_ff == dbws_pkg::DBWS_W32) else $error("32-bit width not taken");

  next8_c_a: assert property (@(posedge clk) disable iff (reset)
    (done && width_ff == dbws_pkg::DBWS_W8 && lane_enable_n_ff == 4'hc)
    |=> lane_enable_n_ff == 4'hd) else $error("bad 8-bit next enables");

  next8_8_a: assert property (@(posedge clk) disable iff (reset)
    (done && width_ff == dbws_pkg::DBWS_W8 && lane_enable_n_ff == 4'h8)
    |=> lane_enable_n_ff == 4'h9) else $error("bad 8-bit next enables");

  next8_9_a: assert property (@(posedge clk) disable iff (reset)
    (done && width_ff == dbws_pkg::DBWS_W8 && lane_enable_n_ff == 4'h9)
    |=> lane_enable_n_ff == 4'hb) else $error("bad 8-bit next enables");

  next8_1_a: assert property (@(posedge clk) disable iff (reset)
    (done && width_ff == dbws_pkg::DBWS_W8 && lane_enable_n_ff == 4'h1)
    |=> lane_enable_n_ff == 4'h3) else $error("bad 8-bit next enables");

  next8_3_a: assert property (@(posedge clk) disable iff (reset)
    (done && width_ff == dbws_pkg::DBWS_W8 && lane_enable_n_ff == 4'h3)
    |=> lane_enable_n_ff == 4'h7) else $error("bad 8-bit next enables");

  single8_a: assert property (@(posedge clk) disable iff (reset)
    (done && width_ff == dbws_pkg::DBWS_W8 && lane_enable_n_ff inside {4'he, 4'hd, 4'hb, 4'h7})
    |-> !more) else $error("extra 8-bit cycle");

  next16_0_a: assert property (@(posedge clk) disable iff (reset)
    (done && width_ff == dbws_pkg::DBWS_W16 && lane_enable_n_ff == 4'h0)
    |=> lane_enable_n_ff == 4'h3) else $error("bad 16-bit next enables");

  next16_9_a: assert property (@(posedge clk) disable iff (reset)
    (done && width_ff == dbws_pkg::DBWS_W16 && lane_enable_n_ff == 4'h9)
    |=> lane_enable_n_ff == 4'hb) else $error("bad 16-bit next enables");

  next16_1_a: assert property (@(posedge clk) disable iff (reset)
    (done && width_ff == dbws_pkg::DBWS_W16 && lane_enable_n_ff == 4'h1)
    |=> lane_enable_n_ff == 4'h3) else $error("bad 16-bit next enables");

  single16_a: assert property (@(posedge clk) disable iff (reset)
    (done && width_ff == dbws_pkg::DBWS_W16 &&
     lane_enable_n_ff inside {4'he, 4'hc, 4'hd, 4'hb, 4'h3, 4'h7})
    |-> !more) else $error("extra 16-bit cycle");

  wide32_a: assert property (@(posedge clk) disable iff (reset)
    (done && width_ff == dbws_pkg::DBWS_W32)
    |-> !more) else $error("extra 32-bit cycle");

  take8_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == DBWS_BUS && width_ff == dbws_pkg::DBWS_W8)
    |-> $onehot0(take)) else $error("8-bit read on several lanes");

  take16_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == DBWS_BUS && width_ff == dbws_pkg::DBWS_W16)
    |-> (take[1:0] == 2'h0 || take[3:2] == 2'h0)) else $error("16-bit read on both halves");

  take_lane_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == DBWS_BUS && lane_enable_n_ff != 4'hf)
    |-> ((take & lane_enable_n_ff) == 4'h0 && take != 4'h0)) else $error("read lane not enabled");

  oe_done_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == DBWS_DONE)
    |-> data_lanes_oe_ff == 4'h0) else $error("lanes driven after cycle");

  oe_read_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == DBWS_BUS && !bus_write_ff)
    |-> data_lanes_oe_ff == 4'h0) else $error("lanes driven on read");

  wdata_lane0_a: assert property (@(posedge clk) disable iff (reset)
    (lane_enable_n_ff[0] && data_lanes_oe_ff[0])
    |-> data_lanes_out_ff[7:0] == 8'h0) else $error("write data on disabled lane");

  wdata_lane1_a: assert property (@(posedge clk) disable iff (reset)
    (lane_enable_n_ff[1] && data_lanes_oe_ff[1])
    |-> data_lanes_out_ff[15:8] == 8'h0) else $error("write data on disabled lane");

  wdata_lane2_a: assert property (@(posedge clk) disable iff (reset)
    (lane_enable_n_ff[2] && data_lanes_oe_ff[2])
    |-> data_lanes_out_ff[23:16] == 8'h0) else $error("write data on disabled lane");

  mem_addr_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == DBWS_IDLE && req_valid && !req.is_io)
    |=> upper_word_address_ff == $past(req.word_addr)) else $error("memory address lost");

  first_lanes_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == DBWS_IDLE && req_valid)
    |=> lane_enable_n_ff == $past(req.lane_enable_n)) else $error("first enables lost");

  bus_hold_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == DBWS_BUS && !done)
    |=> ($stable(lane_enable_n_ff) && $stable(upper_word_address_ff)))
    else $error("bus moved mid-cycle");

  done_hold_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == DBWS_DONE && !buf_ready)
    |=> state_ff == DBWS_DONE) else $error("result dropped on stall");

  narrow8_c: cover property (@(posedge clk) done && more && width_ff == dbws_pkg::DBWS_W8);
  narrow16_c: cover property (@(posedge clk) done && more && width_ff == dbws_pkg::DBWS_W16);
  io_drain_c: cover property (@(posedge clk) state_ff == DBWS_DRAIN && !wbuf_empty);
  stall_c: cover property (@(posedge clk) state_ff == DBWS_DONE && !buf_ready);

endmodule

/* testbench/dbws_dev_model.sv */
`timescale 1ns/100ps
module dbws_dev_model #(
  parameter logic [31:0] RD_WORD = 32'h8b5d3f71
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // processor bus
  input  wire logic        bus_start,
  input  wire logic [3:0]  lane_enable_n,
  input  wire logic [1:0]  mode,
  output logic             width16_request_n,
  output logic             width8_request_n,
  output logic             cycle_done_n,
  output logic [31:0]      data_lanes
);
  logic       busy_ff;
  logic [1:0] wait_ff;
  logic [1:0] slow_ff;
  logic [3:0] en;
  logic [3:0] valid;

  // ==========================================================================
  // width decode
  // width held per request
  assign width16_request_n = ~mode[0];
  assign width8_request_n  = ~mode[1];

  // ==========================================================================
  // cycle end, 0 to 3 wait clocks in turn
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_ff      <= 1'b0;
      wait_ff      <= 2'h0;
      slow_ff      <= 2'h0;
      cycle_done_n <= 1'b1;
    end else begin
      cycle_done_n <= 1'b1;
      if (bus_start) begin
        busy_ff <= 1'b1;
        wait_ff <= slow_ff;
        slow_ff <= slow_ff + 2'h1;
      end else if (busy_ff && wait_ff == 2'h0) begin
        busy_ff      <= 1'b0;
        cycle_done_n <= 1'b0;
      end else if (busy_ff) begin
        wait_ff <= wait_ff - 2'h1;
      end
    end
  end

  // ==========================================================================
  // read lanes, inverse bytes where no valid data stands
  // bytes on the addressed lanes that are valid for the width
  always_comb begin
    en    = ~lane_enable_n;
    valid = en;
    if (mode[1])
      valid = en & (~en + 4'h1);
    else if (mode[0])
      valid = (en[1:0] != 2'h0) ? (en & 4'h3) : (en & 4'hc);
    for (int k = 0; k < 4; k++)
      data_lanes[8*k +: 8] = valid[k] ? RD_WORD[8*k +: 8] : ~RD_WORD[8*k +: 8];
  end
endmodule

/* testbench/dbws_tb.sv */
`timescale 1ns/100ps
module dbws_tb;
  typedef struct packed {
    logic [1:0]  mode;
    logic        wr;
    logic [3:0]  be;
    logic [2:0]  n;
    logic [15:0] seq;
  } dbws_row_t;
  localparam logic [31:0] WDATA = 32'ha1b2c3d4;
  localparam logic [31:0] RWORD = 32'h8b5d3f71;
  logic                 clk, reset, req_valid, req_ready, wbuf_empty;
  logic                 resp_valid, resp_ready, bus_start_ff, done_n, w16_n, w8_n, cur_wr;
  logic                 bus_io_ff, bus_write_ff, cur_io;
  logic [29:0]          upper_word_address_ff, exp_addr;
  logic [3:0]           lane_enable_n_ff, data_lanes_oe_ff;
  logic [31:0]          data_lanes_out_ff, data_lanes_in, wm;
  logic [1:0]           mode;
  logic [3:0]           seen_q[$];
  dbws_pkg::dbws_req_t  req;
  dbws_pkg::dbws_resp_t resp;
  dbws_row_t            rows [18];
  int                   n_errors, checks;

  dbws_core u_dut (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .wbuf_empty(wbuf_empty), .resp_valid(resp_valid), .resp_ready(resp_ready),
    .resp(resp), .bus_start_ff(bus_start_ff), .bus_io_ff(bus_io_ff),
    .bus_write_ff(bus_write_ff),
    .upper_word_address_ff(upper_word_address_ff), .lane_enable_n_ff(lane_enable_n_ff),
    .data_lanes_out_ff(data_lanes_out_ff), .data_lanes_oe_ff(data_lanes_oe_ff),
    .data_lanes_in(data_lanes_in), .width16_request_n(w16_n), .width8_request_n(w8_n),
    .cycle_done_n(done_n));
  dbws_dev_model #(.RD_WORD(RWORD)) u_dev (.clk(clk), .reset(reset),
    .bus_start(bus_start_ff), .lane_enable_n(lane_enable_n_ff), .mode(mode),
    .width16_request_n(w16_n), .width8_request_n(w8_n), .cycle_done_n(done_n),
    .data_lanes(data_lanes_in));

  function automatic logic [31:0] lane_mask(input logic [3:0] be_n);
    for (int k = 0; k < 4; k++)
      lane_mask[8*k +: 8] = {8{~be_n[k]}};
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: word %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: lanes %h, want %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic issue(input logic io, input logic wr, input logic [29:0] a,
                       input logic [29:0] exp_a, input logic [3:0] be);
    int i;
    seen_q.delete();
    exp_addr = exp_a;
    cur_wr = wr;
    cur_io = io;
    req_valid <= 1'b1;
    req <= '{io, wr, a, be, WDATA};
    i = 0;
    do begin @(posedge clk); i++; end while (req_ready !== 1'b1 && i < 200);
    req_valid <= 1'b0;
  endtask

  task automatic wait_resp(output dbws_pkg::dbws_resp_t r);
    int i;
    i = 0;
    do begin @(posedge clk); i++; end while (!(resp_valid === 1'b1 && resp_ready) && i < 300);
    r = resp;
  endtask

  // ==========================================================================
  // bus cycle monitor
  assign wm = lane_mask(lane_enable_n_ff);
  always @(posedge clk) begin
    if (bus_start_ff === 1'b1) begin
      seen_q.push_back(lane_enable_n_ff);
      chk_word({2'h0, upper_word_address_ff}, {2'h0, exp_addr});
      chk_nib(data_lanes_oe_ff, cur_wr ? 4'hf : 4'h0);
      chk_nib({2'h0, bus_io_ff, bus_write_ff}, {2'h0, cur_io, cur_wr});
      if (cur_wr) chk_word(data_lanes_out_ff, WDATA & wm);
    end
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  // ==========================================================================
  // tests
  initial begin
    dbws_pkg::dbws_resp_t r;
    int i;
    rows = '{'{2'h0,1'b0,4'h0,3'h1,16'h0000}, '{2'h1,1'b1,4'h0,3'h2,16'h0300},
      '{2'h1,1'b0,4'h8,3'h2,16'h8b00}, '{2'h1,1'b1,4'h9,3'h2,16'h9b00},
      '{2'h1,1'b0,4'h1,3'h2,16'h1300}, '{2'h1,1'b0,4'hc,3'h1,16'hc000},
      '{2'h1,1'b1,4'h3,3'h1,16'h3000}, '{2'h2,1'b0,4'h0,3'h4,16'h0137},
      '{2'h2,1'b1,4'hc,3'h2,16'hcd00}, '{2'h2,1'b0,4'h8,3'h3,16'h89b0},
      '{2'h2,1'b1,4'h9,3'h2,16'h9b00}, '{2'h2,1'b0,4'h1,3'h3,16'h1370},
      '{2'h2,1'b1,4'h3,3'h2,16'h3700}, '{2'h2,1'b0,4'he,3'h1,16'he000},
      '{2'h2,1'b1,4'hd,3'h1,16'hd000}, '{2'h2,1'b0,4'hb,3'h1,16'hb000},
      '{2'h2,1'b1,4'h7,3'h1,16'h7000}, '{2'h3,1'b0,4'h0,3'h4,16'h0137}};
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    wbuf_empty = 1'b1;
    resp_ready = 1'b1;
    mode = 2'h0;
    cur_wr = 1'b0;
    cur_io = 1'b0;
    exp_addr = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (rows[j]) begin
      mode <= rows[j].mode;
      issue(1'b0, rows[j].wr, 30'h0123_4567, 30'h0123_4567, rows[j].be);
      wait_resp(r);
      chk_word(32'(seen_q.size()), 32'(rows[j].n));
      for (i = 0; i < rows[j].n; i++)
        chk_nib(seen_q[i], rows[j].seq[15-4*i -: 4]);
      if (!rows[j].wr)
        chk_word(r.rdata & lane_mask(rows[j].be), RWORD & lane_mask(rows[j].be));
      $display("test row %0d done", j);
    end
    mode <= 2'h0;
    wbuf_empty <= 1'b0;
    issue(1'b1, 1'b0, 30'h3fff_ffff, 30'h0000_3fff, 4'h0);
    repeat (6) @(posedge clk);
    chk_word(32'(seen_q.size()), 32'h0);
    wbuf_empty <= 1'b1;
    wait_resp(r);
    chk_word(32'(seen_q.size()), 32'h1);
    $display("test io drain done");
    resp_ready <= 1'b0;
    mode <= 2'h2;
    issue(1'b0, 1'b0, 30'h3fff_ffff, 30'h3fff_ffff, 4'h0);
    i = 0;
    do begin @(posedge clk); i++; end while (resp_valid !== 1'b1 && i < 300);
    mode <= 2'h0;
    issue(1'b0, 1'b1, 30'h3fff_ffff, 30'h3fff_ffff, 4'h0);
    repeat (8) @(posedge clk);
    chk_nib({3'h0, resp_valid}, 4'h1);
    issue(1'b0, 1'b0, 30'h0000_0100, 30'h0000_0100, 4'hc);
    repeat (8) @(posedge clk);
    chk_nib({3'h0, req_ready}, 4'h0);
    resp_ready <= 1'b1;
    wait_resp(r);
    chk_word(r.rdata, RWORD);
    wait_resp(r);
    chk_nib({3'h0, r.write}, 4'h1);
    wait_resp(r);
    chk_word(r.rdata & lane_mask(4'hc), RWORD & lane_mask(4'hc));
    $display("test stall done");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    chk_nib(lane_enable_n_ff, 4'hf);
    chk_nib({1'h0, resp_valid, bus_start_ff, req_ready}, 4'h1);
    reset <= 1'b0;
    @(posedge clk);
    issue(1'b0, 1'b0, 30'h0000_0040, 30'h0000_0040, 4'h0);
    wait_resp(r);
    chk_word(r.rdata, RWORD);
    $display("test reset done");
    stop_test();
  end
endmodule
